// File: bench/scr_net_model.sv
// Network-side model: turns telegram requests into event strobes.
// Assumes the bench calls its tasks just after a sys_clk rising edge.
`timescale 1ns/1ps
module scr_net_model
(
	input wire logic sys_clk,
	output logic rxByte,
	output logic rxByteError,
	output logic rxCheckOk,
	output logic rxCheckBad,
	output logic txTelegram
);
	// All strobes idle low from time zero
	initial
	begin
		rxByte = 1'b0;
		rxByteError = 1'b0;
		rxCheckOk = 1'b0;
		rxCheckBad = 1'b0;
		txTelegram = 1'b0;
	end

	// Strobes picked by {rxByte, rxCheckOk, rxCheckBad, txTelegram}, then one idle cycle
	task automatic pulse(input logic [3:0] sel);
		{rxByte, rxCheckOk, rxCheckBad, txTelegram} <= sel;
		@(posedge sys_clk);
		{rxByte, rxCheckOk, rxCheckBad, txTelegram} <= 4'h0;
		@(posedge sys_clk);
	endtask

	// Received telegram: bytes, then its check verdict
	task automatic telegram(input int nb, input bit bad);
		int i;
		for (i = 0; i < nb; i++)
			pulse(4'h8);
		if (bad)
			pulse(4'h2);
		else
			pulse(4'h4);
	endtask

	// Sent telegrams back to back, one per cycle; long runs test wrapping
	task automatic tx_burst(input int n);
		txTelegram <= 1'b1;
		repeat (n) @(posedge sys_clk);
		txTelegram <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Errored bytes back to back, one per cycle; long runs test wrapping
	task automatic err_burst(input int n);
		rxByte <= 1'b1;
		rxByteError <= 1'b1;
		repeat (n) @(posedge sys_clk);
		rxByte <= 1'b0;
		rxByteError <= 1'b0;
		@(posedge sys_clk);
	endtask
endmodule

// File: bench/testbench.sv
// Self-checking bench for the register bank over AXI4-Lite.
// Assumes scr_pkg is compiled first and the network model beside it.
`timescale 1ns/1ps
module testbench;
	logic sys_clk, reset_n;
	logic [7:0] awAddr, arAddr;
	logic [31:0] wData, rData;
	logic [3:0] wStrb;
	logic awValid, awReady, wValid, wReady, bValid, bReady;
	logic arValid, arReady, rValid, rReady;
	logic [1:0] bResp, rResp;
	logic [15:0] driveStatus, activeCommand;
	logic alarmActive, faultActive, accessoryPresent, commTimeoutAlarm, commTimeoutFault;
	logic rxByte, rxByteError, rxCheckOk, rxCheckBad, txTelegram, faultResetPulse;
	logic digitalOutputOne, digitalOutputTwo, digitalOutputThree, telegramEnd, telegramDiscard;
	logic [9:0] analogOutput;
	int miscompares, n_tests, nPulse, nEnd, nDrop, cyc, base, i;
	logic [15:0] pat [4] = '{16'h0001, 16'hd555, 16'h2aaa, 16'hffff};
	logic [4:0] ifTab [5] = '{5'h00, 5'h0c, 5'h16, 5'h15, 5'h01};

	scr_regs DUT (.sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .driveStatus(driveStatus), .alarmActive(alarmActive),
		.faultActive(faultActive), .accessoryPresent(accessoryPresent),
		.commTimeoutAlarm(commTimeoutAlarm), .commTimeoutFault(commTimeoutFault),
		.rxByte(rxByte), .rxByteError(rxByteError), .rxCheckOk(rxCheckOk),
		.rxCheckBad(rxCheckBad), .txTelegram(txTelegram),
		.faultResetPulse(faultResetPulse), .activeCommand(activeCommand),
		.digitalOutputOne(digitalOutputOne), .digitalOutputTwo(digitalOutputTwo),
		.digitalOutputThree(digitalOutputThree), .analogOutput(analogOutput),
		.telegramEnd(telegramEnd), .telegramDiscard(telegramDiscard));

	scr_net_model net (.sys_clk(sys_clk), .rxByte(rxByte), .rxByteError(rxByteError),
		.rxCheckOk(rxCheckOk), .rxCheckBad(rxCheckBad), .txTelegram(txTelegram));

	// 40 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Counts output pulses and cycles; a held level would count several
	always @(posedge sys_clk)
	begin
		nPulse <= nPulse + int'(faultResetPulse === 1'b1);
		nEnd <= nEnd + int'(telegramEnd === 1'b1);
		nDrop <= nDrop + int'(telegramDiscard === 1'b1);
		cyc <= cyc + 1;
	end

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH at %0t: response %h, expected %h", $time, got, exp);
		end
	endtask

	// AXI write; address and data offered together, bready held high
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		bit done;
		done = 0;
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		for (int k = 0; k < 64 && !done; k++)
		begin
			@(posedge sys_clk);
			if (awValid && awReady)
				awValid <= 1'b0;
			if (wValid && wReady)
				wValid <= 1'b0;
			if (bValid === 1'b1)
			begin
				r = bResp;
				done = 1;
			end
		end
		if (done)
			cmp_resp(r, er);
		else
		begin
			miscompares++;
			close_out();
		end
	endtask

	// AXI read and check of data and response
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] got;
		logic [1:0] r;
		bit done;
		done = 0;
		arAddr <= a;
		arValid <= 1'b1;
		for (int k = 0; k < 64 && !done; k++)
		begin
			@(posedge sys_clk);
			if (arValid && arReady)
				arValid <= 1'b0;
			if (rValid === 1'b1)
			begin
				got = rData;
				r = rResp;
				done = 1;
			end
		end
		if (done)
		begin
			cmp_val(got, e);
			cmp_resp(r, er);
		end
		else
		begin
			miscompares++;
			close_out();
		end
	endtask

	// Lets registered outputs catch up with the last write
	task automatic settle();
		repeat (6) @(posedge sys_clk);
	endtask

	initial
	begin
		reset_n = 1'b0;
		{awAddr, arAddr, wData, awValid, wValid, arValid} = '0;
		wStrb = 4'hf;
		bReady = 1'b1;
		rReady = 1'b1;
		driveStatus = 16'h0000;
		{alarmActive, faultActive, accessoryPresent} = '0;
		{commTimeoutAlarm, commTimeoutFault} = '0;
		{miscompares, n_tests, nPulse} = '0;
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		// Reset state and unmapped place
		rd_chk(scr_pkg::ADDR_CMD1, 32'h0, scr_pkg::RESP_OKAY);
		rd_chk(scr_pkg::ADDR_AOUT, 32'h0, scr_pkg::RESP_OKAY);
		rd_chk(8'h3c, 32'h0, scr_pkg::RESP_SLVERR);
		wr(8'h3c, 32'h1, scr_pkg::RESP_SLVERR);
		// Local source active: reserved bits and slot run bits dropped
		wr(scr_pkg::ADDR_CMD1, 32'h0000ffff, scr_pkg::RESP_OKAY);
		rd_chk(scr_pkg::ADDR_CMD1, 32'h0000009a, scr_pkg::RESP_OKAY);
		cmp_val({16'h0, activeCommand}, 32'h0);
		// Slot one active, slot two keeps its own word minus run bits
		wr(scr_pkg::ADDR_ACTSRC, 32'h1, scr_pkg::RESP_OKAY);
		wr(scr_pkg::ADDR_CMD1, 32'h0000001f, scr_pkg::RESP_OKAY);
		wr(scr_pkg::ADDR_CMD2, 32'h0000001f, scr_pkg::RESP_OKAY);
		rd_chk(scr_pkg::ADDR_CMD1, 32'h0000001f, scr_pkg::RESP_OKAY);
		rd_chk(scr_pkg::ADDR_CMD2, 32'h0000001a, scr_pkg::RESP_OKAY);
		cmp_val({16'h0, activeCommand}, 32'h0000001f);
		wr(scr_pkg::ADDR_ACTSRC, 32'h2, scr_pkg::RESP_OKAY);
		rd_chk(scr_pkg::ADDR_CMD1, 32'h0000001a, scr_pkg::RESP_OKAY);
		cmp_val({16'h0, activeCommand}, 32'h0000001a);
		wr(scr_pkg::ADDR_ACTSRC, 32'h3, scr_pkg::RESP_OKAY);
		settle();
		cmp_val({16'h0, activeCommand}, 32'h0);
		// Fault reset only on a rising bit 7 while faulted
		wr(scr_pkg::ADDR_ACTSRC, 32'h1, scr_pkg::RESP_OKAY);
		faultActive <= 1'b1;
		base = nPulse;
		wr(scr_pkg::ADDR_CMD1, 32'h00000080, scr_pkg::RESP_OKAY);
		settle();
		cmp_val(nPulse - base, 1);
		wr(scr_pkg::ADDR_CMD1, 32'h00000080, scr_pkg::RESP_OKAY);
		settle();
		cmp_val(nPulse - base, 1);
		faultActive <= 1'b0;
		wr(scr_pkg::ADDR_CMD1, 32'h0, scr_pkg::RESP_OKAY);
		wr(scr_pkg::ADDR_CMD1, 32'h00000080, scr_pkg::RESP_OKAY);
		settle();
		cmp_val(nPulse - base, 1);
		// Status word: drive bits 0-13, alarm 14, fault 15
		for (i = 0; i < 4; i++)
		begin
			driveStatus <= pat[i];
			alarmActive <= i[0];
			faultActive <= i[1];
			settle();
			rd_chk(scr_pkg::ADDR_STATUS, {16'h0, i[1], i[0], pat[i][13:0]},
				scr_pkg::RESP_OKAY);
		end
		faultActive <= 1'b0;
		// Digital outputs follow bits 0-2
		for (i = 0; i < 2; i++)
		begin
			wr(scr_pkg::ADDR_DOUT, i ? 32'h00000002 : 32'h0000fffd, scr_pkg::RESP_OKAY);
			settle();
			cmp_val({29'h0, digitalOutputThree, digitalOutputTwo, digitalOutputOne},
				i ? 32'h2 : 32'h5);
		end
		rd_chk(scr_pkg::ADDR_DOUT, 32'h2, scr_pkg::RESP_OKAY);
		// Analog output: full scale and a 10-bit cut of a wide write
		wr(scr_pkg::ADDR_AOUT, 32'h000003ff, scr_pkg::RESP_OKAY);
		settle();
		cmp_val({22'h0, analogOutput}, 32'h3ff);
		wr(scr_pkg::ADDR_AOUT, 32'h0000fe01, scr_pkg::RESP_OKAY);
		rd_chk(scr_pkg::ADDR_AOUT, 32'h201, scr_pkg::RESP_OKAY);
		cmp_val({22'h0, analogOutput}, 32'h201);
		// Interface state: {expected, present, alarm, fault}
		for (i = 0; i < 5; i++)
		begin
			accessoryPresent <= ifTab[i][2];
			commTimeoutAlarm <= ifTab[i][1];
			commTimeoutFault <= ifTab[i][0];
			settle();
			rd_chk(scr_pkg::ADDR_IFST, {30'h0, ifTab[i][4:3]}, scr_pkg::RESP_OKAY);
		end
		// Telegram traffic and counters
		for (i = 0; i < 3; i++)
			net.telegram(4, 1'b0);
		net.telegram(3, 1'b1);
		net.tx_burst(2);
		settle();
		rd_chk(scr_pkg::ADDR_RXCNT, 32'h4, scr_pkg::RESP_OKAY);
		rd_chk(scr_pkg::ADDR_BADCNT, 32'h1, scr_pkg::RESP_OKAY);
		rd_chk(scr_pkg::ADDR_TXCNT, 32'h2, scr_pkg::RESP_OKAY);
		rd_chk(scr_pkg::ADDR_BERRCNT, 32'h0, scr_pkg::RESP_OKAY);
		// Errored bytes mark the frame; the quiet gap then closes and drops it
		net.err_burst(3);
		base = cyc;
		// 65535 more sent telegrams inside the gap: wraps past 65535 to 1
		net.tx_burst(65535);
		settle();
		rd_chk(scr_pkg::ADDR_TXCNT, 32'h1, scr_pkg::RESP_OKAY);
		rd_chk(scr_pkg::ADDR_BERRCNT, 32'h3, scr_pkg::RESP_OKAY);
		repeat (scr_pkg::GAP_CYCLES - 8 - (cyc - base)) @(posedge sys_clk);
		cmp_val(nEnd, 0);
		repeat (16) @(posedge sys_clk);
		cmp_val(nEnd, 1);
		cmp_val(nDrop, 1);
		close_out();
	end
endmodule

// File: hw/scr_gap_timer.sv
// Receive gap timer: flags telegram end after a quiet 3.5 byte-time gap.
// Assumes rxByte pulses once per received byte, synchronous to sys_clk.
`timescale 1ns/1ps
module scr_gap_timer
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic rxByte,
	output logic gapExpired,
	output logic inFrame
);
	logic [16:0] gap_r;
	logic inFrame_r;
	logic expired_r;

	// Count quiet time since the last byte; restart on each byte
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			gap_r <= 17'h00000;
		else if (rxByte)
			gap_r <= 17'h00000;
		else if (inFrame_r && gap_r < scr_pkg::GAP_CYCLES_W)
			gap_r <= gap_r + 17'h00001;
	end

	// Frame open from first byte until the gap closes it
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			inFrame_r <= 1'b0;
			expired_r <= 1'b0;
		end
		else
		begin
			expired_r <= 1'b0;
			if (rxByte)
				inFrame_r <= 1'b1;
			else if (inFrame_r && gap_r == scr_pkg::GAP_CYCLES_W - 17'h00001)
			begin
				inFrame_r <= 1'b0;
				expired_r <= 1'b1;
			end
		end
	end

	assign gapExpired = expired_r;
	assign inFrame = inFrame_r;
endmodule

// File: hw/scr_regs.sv
// Top of the communication status and command register bank, AXI4-Lite slave.
// Assumes status, event and slot inputs arrive from logic on sys_clk.
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module scr_regs
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] driveStatus,
	input wire logic alarmActive,
	input wire logic faultActive,
	input wire logic accessoryPresent,
	input wire logic commTimeoutAlarm,
	input wire logic commTimeoutFault,
	input wire logic rxByte,
	input wire logic rxByteError,
	input wire logic rxCheckOk,
	input wire logic rxCheckBad,
	input wire logic txTelegram,
	output logic faultResetPulse,
	output logic [15:0] activeCommand,
	output logic digitalOutputOne,
	output logic digitalOutputTwo,
	output logic digitalOutputThree,
	output logic [9:0] analogOutput,
	output logic telegramEnd,
	output logic telegramDiscard
);
	logic [7:0] awAddr_r;
	logic awHave_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic wHave_r;
	logic bValid_r;
	logic [1:0] bResp_r;
	logic rValid_r;
	logic [31:0] rData_r;
	logic [1:0] rResp_r;
	logic [15:0] cmd1_r;
	logic [15:0] cmd2_r;
	logic [15:0] cmdNew;
	logic [15:0] dout_r;
	logic [9:0] aout_r;
	logic [1:0] actSrc_r;
	logic [15:0] status_r;
	logic [1:0] ifState_r;
	logic [15:0] active_r;
	logic prevReset_r;
	logic fResetPulse_r;
	logic doWrite;
	logic wrCmd1;
	logic wrCmd2;
	logic gapExpired;
	logic inFrame;
	logic discard_r;
	logic end_r;
	logic frameBad_r;
	logic rxTelegramDone;
	logic [31:0] rdMux;
	logic rdHit;
	logic wrHit;
	scr_cnt_if rxCnt();
	scr_cnt_if txCnt();
	scr_cnt_if badCnt();
	scr_cnt_if errCnt();

	// Write address and data captured independently, either order
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			awHave_r <= 1'b0;
			awAddr_r <= 8'h00;
			wHave_r <= 1'b0;
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHave_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			else if (doWrite)
				awHave_r <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHave_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			else if (doWrite)
				wHave_r <= 1'b0;
		end
	end

	// Ready only while the holding slot is empty and no response pends
	assign s_axi_awready = !awHave_r && !bValid_r;
	assign s_axi_wready = !wHave_r && !bValid_r;
	assign doWrite = awHave_r && wHave_r && !bValid_r;

	// Decode; every mapped word answers OKAY, read-only ones drop the data, the rest answer SLVERR
	always_comb
	begin
		wrHit = 1'b0;
		unique case (awAddr_r)
			scr_pkg::ADDR_CMD1, scr_pkg::ADDR_CMD2, scr_pkg::ADDR_DOUT,
			scr_pkg::ADDR_AOUT, scr_pkg::ADDR_ACTSRC: wrHit = 1'b1;
			scr_pkg::ADDR_STATUS, scr_pkg::ADDR_IFST, scr_pkg::ADDR_RXCNT,
			scr_pkg::ADDR_TXCNT, scr_pkg::ADDR_BADCNT, scr_pkg::ADDR_BERRCNT: wrHit = 1'b1;
			default: wrHit = 1'b0;
		endcase
	end
	assign wrCmd1 = doWrite && awAddr_r == scr_pkg::ADDR_CMD1;
	assign wrCmd2 = doWrite && awAddr_r == scr_pkg::ADDR_CMD2;
	// Reserved bits dropped; a byte lane with its strobe low writes zero
	assign cmdNew = {wStrb_r[1] ? wData_r[15:8] : 8'h00, wStrb_r[0] ? wData_r[7:0] : 8'h00}
		& scr_pkg::CMD_KEEP_MASK;

	// Write response, one per accepted pair
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bValid_r <= 1'b0;
			bResp_r <= scr_pkg::RESP_OKAY;
		end
		else if (doWrite)
		begin
			bValid_r <= 1'b1;
			bResp_r <= wrHit ? scr_pkg::RESP_OKAY : scr_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			bValid_r <= 1'b0;
	end

	// Per-slot command words; inactive slot loses run and inching bits
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cmd1_r <= scr_pkg::CMD_RESET;
			cmd2_r <= scr_pkg::CMD_RESET;
		end
		else
		begin
			if (wrCmd1)
				cmd1_r <= cmdNew;
			else if (actSrc_r != 2'(scr_pkg::SRC_SLOT1))
				cmd1_r <= cmd1_r & ~scr_pkg::RUN_BITS_MASK;
			if (wrCmd2)
				cmd2_r <= cmdNew;
			else if (actSrc_r != 2'(scr_pkg::SRC_SLOT2))
				cmd2_r <= cmd2_r & ~scr_pkg::RUN_BITS_MASK;
		end
	end

	// Outputs and active source selection
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dout_r <= 16'h0000;
			aout_r <= scr_pkg::AOUT_RESET;
			actSrc_r <= 2'(scr_pkg::SRC_LOCAL);
		end
		else if (doWrite && wStrb_r[0])
		begin
			if (awAddr_r == scr_pkg::ADDR_DOUT)
				dout_r <= wData_r[15:0] & scr_pkg::DOUT_MASK;
			if (awAddr_r == scr_pkg::ADDR_AOUT && wStrb_r[1])
				aout_r <= wData_r[9:0];
			if (awAddr_r == scr_pkg::ADDR_ACTSRC)
				actSrc_r <= wData_r[1:0];
		end
	end

	// Active command view and fault reset edge detect on the active word
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			active_r <= 16'h0000;
			prevReset_r <= 1'b0;
			fResetPulse_r <= 1'b0;
		end
		else
		begin
			unique case (actSrc_r)
				2'(scr_pkg::SRC_SLOT1): active_r <= cmd1_r;
				2'(scr_pkg::SRC_SLOT2): active_r <= cmd2_r;
				default: active_r <= 16'h0000;
			endcase
			prevReset_r <= active_r[scr_pkg::CMD_FRESET];
			fResetPulse_r <= active_r[scr_pkg::CMD_FRESET] && !prevReset_r
				&& faultActive;
		end
	end

	// Status word and interface state sampled from device logic
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			status_r <= 16'h0000;
			ifState_r <= scr_pkg::IF_OFF;
		end
		else
		begin
			status_r <= {faultActive, alarmActive, driveStatus[13:0]};
			if (!accessoryPresent)
				ifState_r <= scr_pkg::IF_OFF;
			else if (commTimeoutAlarm || commTimeoutFault)
				ifState_r <= scr_pkg::IF_TIMEOUT;
			else
				ifState_r <= scr_pkg::IF_ON;
		end
	end

	// Telegram framing: bad bytes mark the frame, gap closes it
	scr_gap_timer gapTimer
	(
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.rxByte(rxByte),
		.gapExpired(gapExpired),
		.inFrame(inFrame)
	);

	// A frame ended by timeout after an errored byte is discarded
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			frameBad_r <= 1'b0;
			discard_r <= 1'b0;
			end_r <= 1'b0;
		end
		else
		begin
			end_r <= gapExpired;
			discard_r <= gapExpired && frameBad_r;
			if (rxByteError)
				frameBad_r <= 1'b1; // Set wins, so a bad opening byte is kept
			else if (gapExpired || !inFrame)
				frameBad_r <= 1'b0;
		end
	end

	assign rxTelegramDone = rxCheckOk || rxCheckBad;
	assign rxCnt.inc = rxTelegramDone;
	assign txCnt.inc = txTelegram;
	assign badCnt.inc = rxCheckBad;
	assign errCnt.inc = rxByteError;

	scr_wrap_counter rxCounter (.sys_clk(sys_clk), .reset_n(reset_n), .cnt(rxCnt));
	scr_wrap_counter txCounter (.sys_clk(sys_clk), .reset_n(reset_n), .cnt(txCnt));
	scr_wrap_counter badCounter (.sys_clk(sys_clk), .reset_n(reset_n), .cnt(badCnt));
	scr_wrap_counter errCounter (.sys_clk(sys_clk), .reset_n(reset_n), .cnt(errCnt));

	// Read mux; upper bits read zero
	always_comb
	begin
		rdMux = 32'h00000000;
		rdHit = 1'b1;
		unique case (s_axi_araddr)
			scr_pkg::ADDR_STATUS: rdMux = {16'h0000, status_r};
			scr_pkg::ADDR_CMD1: rdMux = {16'h0000, cmd1_r};
			scr_pkg::ADDR_CMD2: rdMux = {16'h0000, cmd2_r};
			scr_pkg::ADDR_DOUT: rdMux = {16'h0000, dout_r};
			scr_pkg::ADDR_AOUT: rdMux = {22'h000000, aout_r};
			scr_pkg::ADDR_IFST: rdMux = {30'h00000000, ifState_r};
			scr_pkg::ADDR_RXCNT: rdMux = {16'h0000, rxCnt.value};
			scr_pkg::ADDR_TXCNT: rdMux = {16'h0000, txCnt.value};
			scr_pkg::ADDR_BADCNT: rdMux = {16'h0000, badCnt.value};
			scr_pkg::ADDR_BERRCNT: rdMux = {16'h0000, errCnt.value};
			scr_pkg::ADDR_ACTSRC: rdMux = {30'h00000000, actSrc_r};
			default: rdHit = 1'b0;
		endcase
	end

	// Read channel, one outstanding read
	assign s_axi_arready = !rValid_r;
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rValid_r <= 1'b0;
			rData_r <= 32'h00000000;
			rResp_r <= scr_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && !rValid_r)
		begin
			rValid_r <= 1'b1;
			rData_r <= rdMux;
			rResp_r <= rdHit ? scr_pkg::RESP_OKAY : scr_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			rValid_r <= 1'b0;
	end

	assign s_axi_bvalid = bValid_r;
	assign s_axi_bresp = bResp_r;
	assign s_axi_rvalid = rValid_r;
	assign s_axi_rdata = rData_r;
	assign s_axi_rresp = rResp_r;
	assign faultResetPulse = fResetPulse_r;
	assign activeCommand = active_r;
	assign digitalOutputOne = dout_r[0];
	assign digitalOutputTwo = dout_r[1];
	assign digitalOutputThree = dout_r[2];
	assign analogOutput = aout_r;
	assign telegramEnd = end_r;
	assign telegramDiscard = discard_r;

	AST_FRESET_EDGE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		faultResetPulse |-> $past(faultActive) && $past(prevReset_r) == 1'b0
		&& $past(active_r[scr_pkg::CMD_FRESET]))
		else $error("fault reset without rising edge");
	AST_FRESET_ONCE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		faultResetPulse |=> !faultResetPulse)
		else $error("fault reset repeated");
	AST_INACTIVE_CLR: assert property (@(posedge sys_clk) disable iff (!reset_n)
		actSrc_r != 2'(scr_pkg::SRC_SLOT1) && !wrCmd1 |=> (cmd1_r & scr_pkg::RUN_BITS_MASK) == 16'h0000)
		else $error("inactive slot kept run bits");
	AST_CMD_RSVD: assert property (@(posedge sys_clk) disable iff (!reset_n)
		((cmd1_r | cmd2_r) & ~scr_pkg::CMD_KEEP_MASK) == 16'h0000)
		else $error("reserved command bit set");
	AST_STATUS_FAULT: assert property (@(posedge sys_clk) disable iff (!reset_n)
		##1 status_r[15] == $past(faultActive) && status_r[14] == $past(alarmActive))
		else $error("status alarm or fault wrong");
	AST_STATUS_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
		##1 status_r[13:0] == $past(driveStatus[13:0]))
		else $error("status low bits wrong");
	AST_IF_STATE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!accessoryPresent |=> ifState_r == scr_pkg::IF_OFF)
		else $error("interface state not off");
	AST_IF_TIMEOUT: assert property (@(posedge sys_clk) disable iff (!reset_n)
		accessoryPresent && commTimeoutFault |=> ifState_r == scr_pkg::IF_TIMEOUT)
		else $error("interface timeout not shown");
	AST_DOUT: assert property (@(posedge sys_clk) disable iff (!reset_n)
		dout_r[15:3] == 13'h0000)
		else $error("reserved output bits set");
	AST_BVALID_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	COV_WRITE: cover property (@(posedge sys_clk) disable iff (!reset_n) doWrite);
	COV_READ: cover property (@(posedge sys_clk) disable iff (!reset_n) s_axi_rvalid && s_axi_rready);
	COV_FRESET: cover property (@(posedge sys_clk) disable iff (!reset_n) faultResetPulse);
	COV_GAP: cover property (@(posedge sys_clk) disable iff (!reset_n) telegramEnd);
endmodule

// File: hw/scr_wrap_counter.sv
// Sixteen-bit wrapping event counter.
// Assumes the increment strobe is already synchronous to sys_clk.
`timescale 1ns/1ps
module scr_wrap_counter
(
	input wire logic sys_clk,
	input wire logic reset_n,
	scr_cnt_if.owner cnt
);
	logic [15:0] count_r;

	// Plain modular add, never saturates
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			count_r <= 16'h0000;
		else if (cnt.inc)
			count_r <= count_r + 16'h0001;
	end

	assign cnt.value = count_r;

	AST_CNT_WRAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
		cnt.inc && count_r == 16'hffff |=> count_r == 16'h0000)
		else $error("counter did not wrap");
	AST_CNT_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!cnt.inc |=> $stable(count_r))
		else $error("counter moved without event");
endmodule

// File: pkg/scr_cnt_if.sv
// Interface carrying one event strobe and counter value between bank modules.
// Assumes a single system clock.
`timescale 1ns/1ps
interface scr_cnt_if;
	logic inc;
	logic [15:0] value;
	modport owner (input inc, output value);
	modport user (output inc, input value);
endinterface

// File: pkg/scr_pkg.sv
// Constants, register map and types for the starter communication register bank.
// Assumes a 40 MHz system clock and an AXI4-Lite master in front of the bank.
package scr_pkg;
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_CMD1 = 8'h04;
	localparam logic [7:0] ADDR_CMD2 = 8'h08;
	localparam logic [7:0] ADDR_DOUT = 8'h0c;
	localparam logic [7:0] ADDR_AOUT = 8'h10;
	localparam logic [7:0] ADDR_IFST = 8'h14;
	localparam logic [7:0] ADDR_RXCNT = 8'h18;
	localparam logic [7:0] ADDR_TXCNT = 8'h1c;
	localparam logic [7:0] ADDR_BADCNT = 8'h20;
	localparam logic [7:0] ADDR_BERRCNT = 8'h24;
	localparam logic [7:0] ADDR_ACTSRC = 8'h28;
	localparam int CMD_START = 0;
	localparam int CMD_ENABLE = 1;
	localparam int CMD_INCHING = 2;
	localparam int CMD_DIR = 3;
	localparam int CMD_REMOTE = 4;
	localparam int CMD_FRESET = 7;
	localparam logic [15:0] CMD_KEEP_MASK = 16'h009f;
	localparam logic [15:0] RUN_BITS_MASK = 16'h0005;
	localparam logic [15:0] DOUT_MASK = 16'h0007;
	localparam logic [15:0] CMD_RESET = 16'h0000;
	localparam logic [9:0] AOUT_RESET = 10'h000;
	localparam logic [1:0] IF_OFF = 2'h0;
	localparam logic [1:0] IF_ON = 2'h1;
	localparam logic [1:0] IF_TIMEOUT = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_HZ = 40000000;
	localparam int GAP_US = 2005;
	localparam int GAP_CYCLES = (GAP_US * (CLK_HZ / 1000000));
	localparam logic [16:0] GAP_CYCLES_W = 17'(GAP_CYCLES);
	typedef enum logic [1:0] {SRC_LOCAL, SRC_SLOT1, SRC_SLOT2, SRC_OTHER} scr_src_t;
endpackage
